// [design/pbdt_top.v]
`timescale 1ns/1ns
`default_nettype none
`include "pbdt_defs.vh"

module pbdt_top #(
   parameter CNT_W     = `PBDT_CNT_W,
   parameter LONG_CYC  = `PBDT_LONG_CYC,
   parameter SHORT_CYC = `PBDT_SHORT_CYC
) (
   input  wire                    clk_sys,
   input  wire                    arst_n,
   // APB slave
   input  wire                    psel,
   input  wire                    penable,
   input  wire                    pwrite,
   input  wire [`PBDT_ADDR_W-1:0] paddr,
   input  wire [31:0]             pwdata,
   output wire [31:0]             prdata,
   output wire                    pready,
   output wire                    pslverr,
   // Primary delayed transaction tracking
   input  wire                    pri_dly_queued,
   input  wire                    pri_dly_repeat,
   output wire                    pri_dly_pending,
   output wire                    pri_dly_discard,
   // Secondary delayed transaction tracking
   input  wire                    sec_dly_queued,
   input  wire                    sec_dly_repeat,
   output wire                    sec_dly_pending,
   output wire                    sec_dly_discard,
   // Secondary master fast back-to-back
   input  wire                    sec_b2b_want,
   output wire                    sec_b2b_grant,
   output wire                    sec_fast_b2b_en,
   // Primary system error, open drain
   output wire                    primary_system_error_out_n,
   output wire                    primary_system_error_oe_n,
   // Interrupt
   output wire                    irq
);

   // ----------------------------------------------------------------
   // Control bits
   // ----------------------------------------------------------------
   reg         fb2b_q;
   reg         pshort_q;
   reg         sshort_q;
   reg         tostat_q;
   reg         serren_q;
   reg         serr_oe_n_q;
   reg         serr_out_n_q;
   reg         pdisc_q;
   reg         sdisc_q;
   reg  [31:0] rdata_q;
   reg  [31:0] rdata_d;
   reg         err_d;

   wire        wr_acc;
   wire        rd_acc;
   wire        any_exp;
   wire        tostat_d;
   wire        ctrl_we;
   wire        istat_we;
   wire        imask_we;
   wire        tostat_clr;
   wire        p_run;
   wire        s_run;
   wire        p_exp;
   wire        s_exp;
   wire [CNT_W-1:0] p_cnt;
   wire [CNT_W-1:0] s_cnt;
   wire [`PBDT_NEV-1:0] ev;
   wire [`PBDT_NEV-1:0] ist;
   wire [`PBDT_NEV-1:0] imsk;

   // ----------------------------------------------------------------
   // APB access decode
   // ----------------------------------------------------------------
   function hit_addr;
      input [`PBDT_ADDR_W-1:0] a;
      input [`PBDT_ADDR_W-1:0] ref_a;
      begin
         hit_addr = (a == ref_a);
      end
   endfunction

   function known_addr;
      input [`PBDT_ADDR_W-1:0] a;
      begin
         known_addr = hit_addr(a, `PBDT_A_CTRL)  | hit_addr(a, `PBDT_A_ISTAT) |
                      hit_addr(a, `PBDT_A_IMASK) | hit_addr(a, `PBDT_A_TSTAT) |
                      hit_addr(a, `PBDT_A_PCNT)  | hit_addr(a, `PBDT_A_SCNT);
      end
   endfunction

   // Zero wait state: every access completes in its first access cycle
   assign pready  = 1'b1;
   assign wr_acc  = psel & penable & pwrite;
   assign rd_acc  = psel & ~penable & ~pwrite;

   // ----------------------------------------------------------------
   // Register write strobes
   // ----------------------------------------------------------------
   assign ctrl_we    = wr_acc & hit_addr(paddr, `PBDT_A_CTRL);
   assign istat_we   = wr_acc & hit_addr(paddr, `PBDT_A_ISTAT);
   assign imask_we   = wr_acc & hit_addr(paddr, `PBDT_A_IMASK);
   // Only a one written to bit 26 clears; a zero leaves the flag alone
   assign tostat_clr = ctrl_we & pwdata[`PBDT_B_TOSTAT];

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         fb2b_q   <= `PBDT_RST_BIT;
         pshort_q <= `PBDT_RST_BIT;
         sshort_q <= `PBDT_RST_BIT;
         serren_q <= `PBDT_RST_BIT;
      end else if (ctrl_we) begin
         fb2b_q   <= pwdata[`PBDT_B_FB2B];
         pshort_q <= pwdata[`PBDT_B_PSHORT];
         sshort_q <= pwdata[`PBDT_B_SSHORT];
         serren_q <= pwdata[`PBDT_B_SERREN];
      end
   end

   // ----------------------------------------------------------------
   // Timeout flag
   // ----------------------------------------------------------------
   assign any_exp  = p_exp | s_exp;
   // Expiry in the clearing cycle keeps the flag set
   assign tostat_d = any_exp | (tostat_q & ~tostat_clr);

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         tostat_q <= `PBDT_RST_BIT;
      end else begin
         tostat_q <= tostat_d;
      end
   end

   // ----------------------------------------------------------------
   // Discard timers
   // ----------------------------------------------------------------
   pbdt_discard_timer #(
      .CNT_W     (CNT_W),
      .LONG_CYC  (LONG_CYC),
      .SHORT_CYC (SHORT_CYC)
   ) u_pri_timer (
      .clk_sys   (clk_sys),
      .arst_n    (arst_n),
      .arm       (pri_dly_queued),
      .done      (pri_dly_repeat),
      .short_sel (pshort_q),
      .running   (p_run),
      .expire    (p_exp),
      .count     (p_cnt)
   );

   pbdt_discard_timer #(
      .CNT_W     (CNT_W),
      .LONG_CYC  (LONG_CYC),
      .SHORT_CYC (SHORT_CYC)
   ) u_sec_timer (
      .clk_sys   (clk_sys),
      .arst_n    (arst_n),
      .arm       (sec_dly_queued),
      .done      (sec_dly_repeat),
      .short_sel (sshort_q),
      .running   (s_run),
      .expire    (s_exp),
      .count     (s_cnt)
   );

   // ----------------------------------------------------------------
   // Delayed completion discard
   // ----------------------------------------------------------------
   // Pending falls one cycle before the discard, so a later repeat must requeue
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pdisc_q <= 1'b0;
         sdisc_q <= 1'b0;
      end else begin
         pdisc_q <= p_exp;
         sdisc_q <= s_exp;
      end
   end

   assign pri_dly_pending = p_run;
   assign sec_dly_pending = s_run;
   assign pri_dly_discard = pdisc_q;
   assign sec_dly_discard = sdisc_q;

   // ----------------------------------------------------------------
   // Primary system error pin
   // ----------------------------------------------------------------
   // One cycle low per expiry while serren_q is set; the line is released otherwise
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         serr_oe_n_q  <= 1'b1;
         serr_out_n_q <= 1'b1;
      end else begin
         serr_oe_n_q  <= ~(any_exp & serren_q);
         serr_out_n_q <= ~(any_exp & serren_q);
      end
   end

   assign primary_system_error_out_n = serr_out_n_q;
   assign primary_system_error_oe_n  = serr_oe_n_q;

   // ----------------------------------------------------------------
   // Fast back-to-back on the secondary
   // ----------------------------------------------------------------
   assign sec_fast_b2b_en = fb2b_q;
   assign sec_b2b_grant   = sec_b2b_want & fb2b_q;

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   assign ev[`PBDT_EV_PRI] = p_exp;
   assign ev[`PBDT_EV_SEC] = s_exp;

   pbdt_irq #(
      .N        (`PBDT_NEV)
   ) u_irq (
      .clk_sys  (clk_sys),
      .arst_n   (arst_n),
      .event_in (ev),
      .clr_we   (istat_we),
      .mask_we  (imask_we),
      .wdata    (pwdata[`PBDT_NEV-1:0]),
      .status   (ist),
      .mask     (imsk),
      .irq      (irq)
   );

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // Captured in the setup cycle so prdata comes from a flip-flop
   always @* begin
      rdata_d = 32'h0000_0000;
      err_d   = ~known_addr(paddr);
      if (hit_addr(paddr, `PBDT_A_CTRL)) begin
         rdata_d[`PBDT_B_FB2B]   = fb2b_q;
         rdata_d[`PBDT_B_PSHORT] = pshort_q;
         rdata_d[`PBDT_B_SSHORT] = sshort_q;
         rdata_d[`PBDT_B_TOSTAT] = tostat_q;
         rdata_d[`PBDT_B_SERREN] = serren_q;
         rdata_d[`PBDT_RSV_HI:`PBDT_RSV_LO] = 4'h0;
      end else if (hit_addr(paddr, `PBDT_A_ISTAT)) begin
         rdata_d[`PBDT_NEV-1:0] = ist;
      end else if (hit_addr(paddr, `PBDT_A_IMASK)) begin
         rdata_d[`PBDT_NEV-1:0] = imsk;
      end else if (hit_addr(paddr, `PBDT_A_TSTAT)) begin
         rdata_d[`PBDT_T_PRUN] = p_run;
         rdata_d[`PBDT_T_SRUN] = s_run;
      end else if (hit_addr(paddr, `PBDT_A_PCNT)) begin
         rdata_d[CNT_W-1:0] = p_cnt;
      end else if (hit_addr(paddr, `PBDT_A_SCNT)) begin
         rdata_d[CNT_W-1:0] = s_cnt;
      end
   end

   reg err_q;

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= 32'h0000_0000;
         err_q   <= 1'b0;
      end else if (psel && !penable) begin
         rdata_q <= rd_acc ? rdata_d : 32'h0000_0000;
         err_q   <= err_d;
      end
   end

   assign prdata  = rdata_q;
   assign pslverr = psel & penable & err_q;

endmodule
`default_nettype wire

// [design/pbdt_defs.vh]
`ifndef PBDT_DEFS_VH
`define PBDT_DEFS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define PBDT_ADDR_W        12
`define PBDT_A_CTRL        12'h03c
`define PBDT_A_ISTAT       12'h080
`define PBDT_A_IMASK       12'h084
`define PBDT_A_TSTAT       12'h088
`define PBDT_A_PCNT        12'h08c
`define PBDT_A_SCNT        12'h090

// ----------------------------------------------------------------
// Bridge control word fields
// ----------------------------------------------------------------
`define PBDT_B_FB2B        23
`define PBDT_B_PSHORT      24
`define PBDT_B_SSHORT      25
`define PBDT_B_TOSTAT      26
`define PBDT_B_SERREN      27
`define PBDT_RSV_HI        31
`define PBDT_RSV_LO        28

// ----------------------------------------------------------------
// Interrupt and timer status fields
// ----------------------------------------------------------------
`define PBDT_NEV           2
`define PBDT_EV_PRI        0
`define PBDT_EV_SEC        1
`define PBDT_T_PRUN        0
`define PBDT_T_SRUN        1

// ----------------------------------------------------------------
// Reset values and timer lengths
// ----------------------------------------------------------------
`define PBDT_RST_BIT       1'b0
`define PBDT_RST_EV        2'h0
`define PBDT_CNT_W         16
`define PBDT_LONG_CYC      32768
`define PBDT_SHORT_CYC     1024

`endif

// [design/pbdt_discard_timer.v]
`timescale 1ns/1ns
`default_nettype none
`include "pbdt_defs.vh"

module pbdt_discard_timer #(
   parameter CNT_W     = `PBDT_CNT_W,
   parameter LONG_CYC  = `PBDT_LONG_CYC,
   parameter SHORT_CYC = `PBDT_SHORT_CYC
) (
   input  wire             clk_sys,
   input  wire             arst_n,
   input  wire             arm,
   input  wire             done,
   input  wire             short_sel,
   output wire             running,
   output wire             expire,
   output wire [CNT_W-1:0] count
);

   localparam ST_IDLE = 1'b0;
   localparam ST_RUN  = 1'b1;
   localparam [CNT_W-1:0] LONG_LAST  = LONG_CYC - 1;
   localparam [CNT_W-1:0] SHORT_LAST = SHORT_CYC - 1;
   localparam [CNT_W-1:0] CNT_ONE    = 1;

   reg             state_q;
   reg             state_d;
   reg [CNT_W-1:0] cnt_q;
   reg [CNT_W-1:0] cnt_d;
   reg             exp_q;
   reg             exp_d;
   wire            hit;

   // Length is read live; shortening with the count at or past SHORT_LAST expires at once
   assign hit = cnt_q >= (short_sel ? SHORT_LAST : LONG_LAST);

   always @* begin
      state_d = state_q;
      cnt_d   = cnt_q;
      exp_d   = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (arm) begin
               state_d = ST_RUN;
               cnt_d   = {CNT_W{1'b0}};
            end
         end
         ST_RUN: begin
            if (arm) begin
               cnt_d = {CNT_W{1'b0}};
            end else if (done) begin
               state_d = ST_IDLE;
            end else if (hit) begin
               state_d = ST_IDLE;
               exp_d   = 1'b1;
            end else begin
               cnt_d = cnt_q + CNT_ONE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_IDLE;
         cnt_q   <= {CNT_W{1'b0}};
         exp_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         exp_q   <= exp_d;
      end
   end

   assign running = state_q;
   assign expire  = exp_q;
   assign count   = cnt_q;

endmodule
`default_nettype wire

// [design/pbdt_irq.v]
`timescale 1ns/1ns
`default_nettype none
`include "pbdt_defs.vh"

module pbdt_irq #(
   parameter N = `PBDT_NEV
) (
   input  wire         clk_sys,
   input  wire         arst_n,
   input  wire [N-1:0] event_in,
   input  wire         clr_we,
   input  wire         mask_we,
   input  wire [N-1:0] wdata,
   output wire [N-1:0] status,
   output wire [N-1:0] mask,
   output wire         irq
);

   reg [N-1:0] status_q;
   reg [N-1:0] mask_q;
   reg         irq_q;
   wire [N-1:0] status_d;

   // Set wins over a clear in the same cycle
   assign status_d = (status_q & ~(clr_we ? wdata : {N{1'b0}})) | event_in;

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         status_q <= {N{1'b0}};
         mask_q   <= {N{1'b0}};
         irq_q    <= 1'b0;
      end else begin
         status_q <= status_d;
         if (mask_we) begin
            mask_q <= wdata;
         end
         irq_q <= |(status_q & mask_q);
      end
   end

   assign status = status_q;
   assign mask   = mask_q;
   assign irq    = irq_q;

endmodule
`default_nettype wire

// [testbench/pbdt_chk_sva.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pbdt_defs.vh"

module pbdt_chk_sva #(
   parameter CNT_W     = 16,
   parameter LONG_CYC  = 32768,
   parameter SHORT_CYC = 1024
) (
   input wire logic                    clk_sys,
   input wire logic                    arst_n,
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [`PBDT_ADDR_W-1:0] paddr,
   input wire logic [31:0]             prdata,
   input wire logic                    pri_dly_queued,
   input wire logic                    pri_dly_repeat,
   input wire logic                    pri_dly_pending,
   input wire logic                    pri_dly_discard,
   input wire logic                    sec_dly_queued,
   input wire logic                    sec_dly_repeat,
   input wire logic                    sec_dly_pending,
   input wire logic                    sec_dly_discard,
   input wire logic                    sec_b2b_want,
   input wire logic                    sec_b2b_grant,
   input wire logic                    sec_fast_b2b_en,
   input wire logic                    primary_system_error_out_n,
   input wire logic                    primary_system_error_oe_n
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   b2b_grant_a: assert property (sec_b2b_grant == (sec_b2b_want && sec_fast_b2b_en))
      else $error("fast back-to-back grant mismatch");
   pri_arm_a: assert property (pri_dly_queued |=> pri_dly_pending)
      else $error("primary timer not armed");
   sec_arm_a: assert property (sec_dly_queued |=> sec_dly_pending)
      else $error("secondary timer not armed");
   pri_drop_a: assert property (pri_dly_discard |-> !pri_dly_pending && $past(pri_dly_pending, 2))
      else $error("primary discard without running timer");
   sec_drop_a: assert property (sec_dly_discard |-> !sec_dly_pending && $past(sec_dly_pending, 2))
      else $error("secondary discard without running timer");
   pri_stop_a: assert property (pri_dly_pending && pri_dly_repeat && !pri_dly_queued
      |=> !pri_dly_pending && !pri_dly_discard)
      else $error("primary repeat did not stop timer");
   sec_stop_a: assert property (sec_dly_pending && sec_dly_repeat && !sec_dly_queued
      |=> !sec_dly_pending && !sec_dly_discard)
      else $error("secondary repeat did not stop timer");
   serr_cause_a: assert property (!primary_system_error_oe_n
      |-> (pri_dly_discard || sec_dly_discard) && !primary_system_error_out_n)
      else $error("system error without expiry");
   rsv_zero_a: assert property (psel && penable && !pwrite && paddr == `PBDT_A_CTRL
      |-> prdata[31:28] == 4'h0)
      else $error("reserved control bits not zero");

   cover property (pri_dly_discard);
   cover property (sec_dly_discard);
   cover property (!primary_system_error_oe_n);
   cover property (sec_b2b_grant);
endmodule

`default_nettype wire

// [testbench/pbdt_initiator.sv]
`timescale 1ns/1ns
`default_nettype none

module pbdt_initiator (
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   input  wire logic        start,
   input  wire logic [15:0] delay,
   output var  logic        dly_queued,
   output var  logic        dly_repeat
);
   // ------------------------------------------------------------
   // Retried request, repeated after delay cycles (0: never)
   // ------------------------------------------------------------
   logic [15:0] cnt_q;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         dly_queued <= 1'b0;
         dly_repeat <= 1'b0;
         cnt_q      <= 16'h0;
      end else if (start) begin
         dly_queued <= 1'b1;
         dly_repeat <= 1'b0;
         cnt_q      <= delay;
      end else begin
         dly_queued <= 1'b0;
         dly_repeat <= (cnt_q == 16'h1);
         if (cnt_q != 16'h0) begin
            cnt_q <= cnt_q - 16'h1;
         end
      end
   end
endmodule

`default_nettype wire

// [testbench/pci_bridge_discard_timers_bench.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pbdt_defs.vh"

module pci_bridge_discard_timers_bench;
   // Short lengths keep the run brief
   localparam LC = 64;
   localparam SC = 8;
   logic        clk_sys, arst_n, psel, penable, pwrite, sec_b2b_want, perr;
   logic        p_start, s_start;
   logic [15:0] p_dly, s_dly;
   logic [11:0] paddr;
   logic [31:0] pwdata, rdat;
   int          err_count, comparisons;
   wire  [31:0] prdata;
   wire         pready, pslverr, irq, sec_b2b_grant, sec_fast_b2b_en;
   wire         pri_dly_queued, pri_dly_repeat, pri_dly_pending, pri_dly_discard;
   wire         sec_dly_queued, sec_dly_repeat, sec_dly_pending, sec_dly_discard;
   wire         primary_system_error_out_n, primary_system_error_oe_n;
   // Pulled-up open-drain line
   wire         serr_line = primary_system_error_oe_n ? 1'b1 : primary_system_error_out_n;

   pbdt_top #(.LONG_CYC(LC), .SHORT_CYC(SC)) pbdt_top_i (.clk_sys, .arst_n, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pri_dly_queued, .pri_dly_repeat,
      .pri_dly_pending, .pri_dly_discard, .sec_dly_queued, .sec_dly_repeat, .sec_dly_pending,
      .sec_dly_discard, .sec_b2b_want, .sec_b2b_grant, .sec_fast_b2b_en,
      .primary_system_error_out_n, .primary_system_error_oe_n, .irq);
   pbdt_initiator pri_init_i (.clk_sys, .arst_n, .start(p_start), .delay(p_dly),
      .dly_queued(pri_dly_queued), .dly_repeat(pri_dly_repeat));
   pbdt_initiator sec_init_i (.clk_sys, .arst_n, .start(s_start), .delay(s_dly),
      .dly_queued(sec_dly_queued), .dly_repeat(sec_dly_repeat));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task conclude;
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         err_count++;
      end
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge clk_sys); n++; end while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      perr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (n >= 20) begin err_count++; conclude(); end
   endtask

   // Queued visible after return edge; repeat seen delay edges later
   task launch(input int side, input logic [15:0] d);
      @(posedge clk_sys);
      if (side == 0) begin p_start <= 1'b1; p_dly <= d; end
      else begin s_start <= 1'b1; s_dly <= d; end
      @(posedge clk_sys);
      p_start <= 1'b0; s_start <= 1'b0;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_reset;
      apb(0, `PBDT_A_CTRL, 0);  chk(rdat, 32'h0);
      apb(0, `PBDT_A_ISTAT, 0); chk(rdat, 32'h0);
      apb(0, 12'h100, 0);       chk(rdat, 32'h0);
      chk(perr, 1);
      sec_b2b_want <= 1'b1;
      @(posedge clk_sys); #1;
      chk(sec_b2b_grant, 0);
   endtask

   task t_ctrl_bits;
      apb(1, `PBDT_A_CTRL, 32'hffffffff);
      apb(0, `PBDT_A_CTRL, 0); chk(rdat, 32'h0b800000);
      #1; chk({sec_fast_b2b_en, sec_b2b_grant}, 2'h3);
      @(posedge clk_sys);
      sec_b2b_want <= 1'b0;
      apb(1, `PBDT_A_CTRL, 32'h0);
      #1; chk({sec_fast_b2b_en, sec_b2b_grant}, 2'h0);
   endtask

   task t_expire(input int side, input logic sh, input logic se, input logic mk);
      logic [31:0] cfg;
      int          m;
      cfg = {4'h0, se, 1'b0, sh && side == 1, sh && side == 0, 24'h0};
      apb(1, `PBDT_A_CTRL, cfg);
      apb(1, `PBDT_A_IMASK, mk << side);
      launch(side, 0);
      m = 0;
      do begin @(posedge clk_sys); #1; m++; end
      while (((side == 0) ? pri_dly_discard : sec_dly_discard) !== 1'b1 && m < LC + 10);
      chk(m, (sh ? SC : LC) + 2);
      if (m >= LC + 10) conclude();
      chk(serr_line, !se);
      @(posedge clk_sys); #1;
      chk(irq, mk);
      apb(0, `PBDT_A_CTRL, 0);  chk(rdat, cfg | 32'h04000000);
      apb(0, `PBDT_A_ISTAT, 0); chk(rdat, 1 << side);
      apb(1, `PBDT_A_CTRL, cfg | 32'h04000000);
      apb(1, `PBDT_A_ISTAT, 1 << side);
      apb(0, `PBDT_A_CTRL, 0);  chk(rdat, cfg);
      #1; chk(irq, 0);
   endtask

   // Repeat landing on the expiry edge must still win
   task t_repeat(input int side, input logic sh, input logic [15:0] d);
      logic [31:0] cfg;
      logic        seen;
      int          m;
      cfg = {4'h0, 2'h2, sh && side == 1, sh && side == 0, 24'h0};
      apb(1, `PBDT_A_CTRL, cfg);
      launch(side, d);
      seen = 1'b0;
      for (m = 0; m < d + 6; m++) begin
         @(posedge clk_sys); #1;
         seen = seen | pri_dly_discard | sec_dly_discard | !serr_line;
      end
      chk(seen, 0);
      chk({pri_dly_pending, sec_dly_pending}, 2'h0);
      apb(0, `PBDT_A_CTRL, 0); chk(rdat, cfg);
   endtask

   // Running flag and count are read back while the primary timer runs
   task t_count;
      int m;
      apb(1, `PBDT_A_CTRL, 32'h0);
      launch(0, 0);
      apb(0, `PBDT_A_TSTAT, 0); chk(rdat, 32'h1);
      apb(0, `PBDT_A_PCNT, 0);  chk(rdat, 32'h3);
      m = 0;
      do begin @(posedge clk_sys); #1; m++; end
      while (pri_dly_discard !== 1'b1 && m < LC + 10);
      chk(m, LC - 4);
      if (m >= LC + 10) conclude();
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   initial begin
      err_count = 0; comparisons = 0;
      arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
      pwdata = 32'h0; sec_b2b_want = 1'b0; p_start = 1'b0; s_start = 1'b0;
      p_dly = 16'h0; s_dly = 16'h0;
      repeat (12) @(posedge clk_sys);
      arst_n <= 1'b1;
      t_reset();
      t_ctrl_bits();
      t_expire(0, 0, 1, 1);
      t_expire(0, 1, 0, 0);
      t_expire(1, 0, 0, 1);
      t_expire(1, 1, 1, 0);
      t_repeat(1, 1, SC);
      t_repeat(0, 0, 3);
      t_count();
      conclude();
   end
endmodule

bind pbdt_top pbdt_chk_sva #(.CNT_W(CNT_W), .LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC))
   pbdt_chk_i (.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr, .prdata,
   .pri_dly_queued, .pri_dly_repeat, .pri_dly_pending, .pri_dly_discard, .sec_dly_queued,
   .sec_dly_repeat, .sec_dly_pending, .sec_dly_discard, .sec_b2b_want, .sec_b2b_grant,
   .sec_fast_b2b_en, .primary_system_error_out_n, .primary_system_error_oe_n);

`default_nettype wire
